// ==== spf_params.svh ====
// constants for the sensor pin function select block
//
// Contract
// - chip select high I2C, low SPI
// - interrupt route drives interrupt flag push-pull
// - ready route drives all-axes ready flag
// - four-wire select drives SPI serial output
// - shared pin carries one function at most
// - no route bit: shared pin undriven input
// - data pin: I2C, SPI in, 3-wire out
// - measurement done sets all-axes flag, and axis flags of done axes only
`ifndef SPF_PARAMS_SVH
`define SPF_PARAMS_SVH

// positions of the three routing bits inside the route vector
`define SPF_RT_INT_POS   2
`define SPF_RT_READY_POS 1
`define SPF_RT_SDO_POS   0
`define SPF_RT_WIDTH     3

// reset values
`define SPF_ROUTE_RST    3'h0
`define SPF_CS_RST       1'h1
`define SPF_SCLK_RST     1'h0
`define SPF_SDAT_RST     1'h1
`define SPF_FLAG_RST     1'h0

// pin synchroniser length in flip-flops
`define SPF_SYNC_DEPTH   3
`define SPF_AXES         3

`endif

// ==== spf_pkg.sv ====
// types shared by the pin function select modules
package spf_pkg;

  typedef enum logic [2:0] {
    SPF_ROUTE_NONE,
    SPF_ROUTE_INT,
    SPF_ROUTE_READY,
    SPF_ROUTE_SDO,
    SPF_ROUTE_BAD
  } spf_route_t;

  typedef enum logic {
    SPF_BUS_I2C,
    SPF_BUS_SPI
  } spf_bus_t;

endpackage

// ==== spf_route_if.sv ====
// carrier between the pin core and the shared pin selector
`timescale 1ns/1ps
interface spf_route_if;
  import spf_pkg::*;

  logic [2:0] route_bits;
  logic       int_flag;
  logic       ready_flag;
  logic       sdo_bit;
  logic       pin_out;
  logic       pin_oe;
  spf_route_t route;

  modport sel
  (
    input  route_bits,
    input  int_flag,
    input  ready_flag,
    input  sdo_bit,
    output pin_out,
    output pin_oe,
    output route
  );

  modport core
  (
    output route_bits,
    output int_flag,
    output ready_flag,
    output sdo_bit,
    input  pin_out,
    input  pin_oe,
    input  route
  );
endinterface

// ==== spf_route_sel.sv ====
// shared output pin function selector
`timescale 1ns/1ps
`include "spf_params.svh"
module spf_route_sel
(
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  spf_route_if.sel  rt
);
  import spf_pkg::*;

  logic pin_ff;
  logic pin_oe_ff;

  // one-hot decode; anything with two bits set is flagged, never merged
  always_comb
  begin
    unique case (rt.route_bits)
      3'h0:                        rt.route = SPF_ROUTE_NONE;
      3'h1 << `SPF_RT_INT_POS:     rt.route = SPF_ROUTE_INT;
      3'h1 << `SPF_RT_READY_POS:   rt.route = SPF_ROUTE_READY;
      3'h1 << `SPF_RT_SDO_POS:     rt.route = SPF_ROUTE_SDO;
      default:                     rt.route = SPF_ROUTE_BAD;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      pin_ff    <= 1'h0;
      pin_oe_ff <= 1'h0;
    end
    else
    begin
      unique case (rt.route)
        SPF_ROUTE_INT:
        begin
          pin_ff    <= rt.int_flag;
          pin_oe_ff <= 1'h1;
        end
        SPF_ROUTE_READY:
        begin
          pin_ff    <= rt.ready_flag;
          pin_oe_ff <= 1'h1;
        end
        SPF_ROUTE_SDO:
        begin
          pin_ff    <= rt.sdo_bit;
          pin_oe_ff <= 1'h1;
        end
        // a forbidden mix releases the pin rather than fight two sources
        SPF_ROUTE_BAD:
        begin
          pin_ff    <= 1'h0;
          pin_oe_ff <= 1'h0;
        end
        SPF_ROUTE_NONE:
        begin
          pin_ff    <= 1'h0;
          pin_oe_ff <= 1'h0;
        end
      endcase
    end
  end

  assign rt.pin_out = pin_ff;
  assign rt.pin_oe  = pin_oe_ff;
endmodule

// ==== spf_pin_mux.sv ====
// pin function select core: interface choice, data pin, ready flags
`timescale 1ns/1ps
`include "spf_params.svh"
module spf_pin_mux
#(
  parameter int AXES = `SPF_AXES
)
(
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic             chip_sel_in,
  input  wire logic             serial_port_clock_in,
  input  wire logic             sdat_in,
  output      logic             sdat_out,
  output      logic             sdat_oe_out,
  output      logic             shared_pin_out,
  output      logic             shared_pin_oe_out,
  input  wire logic             int_route_sel_in,
  input  wire logic             ready_route_sel_in,
  input  wire logic             four_wire_out_sel_in,
  input  wire logic             three_wire_sel_in,
  input  wire logic             int_flag_in,
  input  wire logic             sample_done_in,
  input  wire logic [AXES-1:0]  axis_done_in,
  input  wire logic             status_read_in,
  input  wire logic             i2c_sda_low_in,
  input  wire logic             spi_tx_bit_in,
  input  wire logic             spi_tx_en_in,
  output      spf_pkg::spf_bus_t bus_mode_out,
  output      logic             i2c_enable_out,
  output      logic             spi_enable_out,
  output      logic             spc_level_out,
  output      logic             spc_rise_out,
  output      logic             spc_fall_out,
  output      logic             sdat_rx_out,
  output      logic             sample_ready_out,
  output      logic [AXES-1:0]  axis_ready_out,
  output      logic             route_error_out
);
  import spf_pkg::*;

  // the flag logic is written for one to eight axes
  generate
    if (AXES < 1 || AXES > 8)
    begin : g_bad_axes
      $error("spf_pin_mux: AXES must lie in 1..8");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: chip select, serial clock, serial data

  localparam int NPIN = 3;
  localparam int P_CS = 0;
  localparam int P_CK = 1;
  localparam int P_SD = 2;

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_rst;
  logic [NPIN-1:0] s1_ff;
  logic [NPIN-1:0] s2_ff;
  logic [NPIN-1:0] s3_ff;
  logic [NPIN-1:0] lvl_ff;
  logic [NPIN-1:0] nxt_lvl;

  assign pin_raw = {sdat_in, serial_port_clock_in, chip_sel_in};
  assign pin_rst = {`SPF_SDAT_RST, `SPF_SCLK_RST, `SPF_CS_RST};

  genvar gp;
  generate
    for (gp = 0; gp < NPIN; gp++)
    begin : g_sync
      // s1 feeds only s2; the filter looks at s2 and s3 alone
      always_ff @(posedge clk_in)
      begin
        if (!rst_b_in)
        begin
          s1_ff[gp] <= pin_rst[gp];
          s2_ff[gp] <= pin_rst[gp];
          s3_ff[gp] <= pin_rst[gp];
        end
        else
        begin
          s1_ff[gp] <= pin_raw[gp];
          s2_ff[gp] <= s1_ff[gp];
          s3_ff[gp] <= s2_ff[gp];
        end
      end

      // a change only counts once the second and third stage agree
      assign nxt_lvl[gp] = (s2_ff[gp] == s3_ff[gp]) ? s3_ff[gp] : lvl_ff[gp];

      always_ff @(posedge clk_in)
      begin
        if (!rst_b_in)
          lvl_ff[gp] <= pin_rst[gp];
        else
          lvl_ff[gp] <= nxt_lvl[gp];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // interface choice from chip select

  spf_bus_t bus_ff;
  spf_bus_t nxt_bus;

  assign nxt_bus = lvl_ff[P_CS] ? SPF_BUS_I2C : SPF_BUS_SPI;

  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
      bus_ff <= SPF_BUS_I2C;
    else
      bus_ff <= nxt_bus;
  end

  assign bus_mode_out   = bus_ff;
  assign i2c_enable_out = (bus_ff == SPF_BUS_I2C);
  assign spi_enable_out = (bus_ff == SPF_BUS_SPI);

  ////////////////////////////////////////////////////////////////////////////////
  // serial port clock edges, sampled from the host's clock pin

  logic sclk_d_ff;
  logic rise_ff;
  logic fall_ff;

  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      sclk_d_ff <= `SPF_SCLK_RST;
      rise_ff   <= 1'h0;
      fall_ff   <= 1'h0;
    end
    else
    begin
      sclk_d_ff <= lvl_ff[P_CK];
      rise_ff   <= lvl_ff[P_CK] & ~sclk_d_ff;
      fall_ff   <= ~lvl_ff[P_CK] & sclk_d_ff;
    end
  end

  assign spc_level_out = sclk_d_ff;
  assign spc_rise_out  = rise_ff;
  assign spc_fall_out  = fall_ff;
  assign sdat_rx_out   = lvl_ff[P_SD];

  ////////////////////////////////////////////////////////////////////////////////
  // serial data pin: i2c open drain, spi input, 3-wire spi output

  logic sdat_ff;
  logic sdat_oe_ff;

  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      sdat_ff    <= 1'h0;
      sdat_oe_ff <= 1'h0;
    end
    else
    begin
      unique case (bus_ff)
        // open drain: only ever pulls low, the bus pull-up makes the high
        SPF_BUS_I2C:
        begin
          sdat_ff    <= 1'h0;
          sdat_oe_ff <= i2c_sda_low_in;
        end
        // 4-wire leaves the pin an input; 3-wire turns it round to send
        SPF_BUS_SPI:
        begin
          sdat_ff    <= spi_tx_bit_in;
          sdat_oe_ff <= three_wire_sel_in & spi_tx_en_in;
        end
      endcase
    end
  end

  assign sdat_out    = sdat_ff;
  assign sdat_oe_out = sdat_oe_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // new-sample flags: set on completion, cleared by a status read

  logic            all_ready_ff;
  logic [AXES-1:0] axis_ready_ff;

  // a completion in the same cycle as the read keeps the flag set
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
      all_ready_ff <= `SPF_FLAG_RST;
    else if (sample_done_in)
      all_ready_ff <= 1'h1;
    else if (status_read_in)
      all_ready_ff <= 1'h0;
  end

  genvar ga;
  generate
    for (ga = 0; ga < AXES; ga++)
    begin : g_axis
      always_ff @(posedge clk_in)
      begin
        if (!rst_b_in)
          axis_ready_ff[ga] <= `SPF_FLAG_RST;
        else if (sample_done_in & axis_done_in[ga])
          axis_ready_ff[ga] <= 1'h1;
        else if (status_read_in)
          axis_ready_ff[ga] <= 1'h0;
      end
    end
  endgenerate

  assign sample_ready_out = all_ready_ff;
  assign axis_ready_out   = axis_ready_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // shared output pin

  logic [`SPF_RT_WIDTH-1:0] route_bits;

  assign route_bits[`SPF_RT_INT_POS]   = int_route_sel_in;
  assign route_bits[`SPF_RT_READY_POS] = ready_route_sel_in;
  assign route_bits[`SPF_RT_SDO_POS]   = four_wire_out_sel_in;

  spf_route_if u_rt ();

  assign u_rt.route_bits = route_bits;
  assign u_rt.int_flag   = int_flag_in;
  assign u_rt.ready_flag = all_ready_ff;
  assign u_rt.sdo_bit    = spi_tx_bit_in;

  spf_route_sel u_sel
  (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .rt       (u_rt.sel)
  );

  assign shared_pin_out    = u_rt.pin_out;
  assign shared_pin_oe_out = u_rt.pin_oe;
  // a forbidden route setting is reported, the pin stays released
  assign route_error_out   = (u_rt.route == SPF_ROUTE_BAD);
endmodule

// ==== spf_pin_mux_sva.sv ====
// port assertions for the pin function select block
`timescale 1ns/1ps
module spf_pin_mux_sva
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic chip_sel_in,
  input wire logic int_route_sel_in,
  input wire logic ready_route_sel_in,
  input wire logic four_wire_out_sel_in,
  input wire logic int_flag_in,
  input wire logic spi_tx_bit_in,
  input wire logic sample_done_in,
  input wire logic shared_pin_out,
  input wire logic shared_pin_oe_out,
  input wire logic i2c_enable_out,
  input wire logic spi_enable_out,
  input wire logic spc_level_out,
  input wire logic spc_rise_out,
  input wire logic spc_fall_out,
  input wire logic sample_ready_out,
  input wire logic route_error_out
);
  logic [2:0] rt_bits;
  assign rt_bits = {int_route_sel_in, ready_route_sel_in, four_wire_out_sel_in};
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  ////////////////////////////////////////
  // eight samples leave room for the synchroniser and filter latency
  sequence s_cs_low;
    !chip_sel_in [*8];
  endsequence
  sequence s_cs_high;
    chip_sel_in [*8];
  endsequence
  sequence s_ready_held;
    rt_bits == 3'h2 ##1 $stable(sample_ready_out);
  endsequence
  ////////////////////////////////////////
  a_spi_chosen: assert property (s_cs_low |-> spi_enable_out && !i2c_enable_out)
    else $error("spi not chosen");
  a_i2c_chosen: assert property (s_cs_high |-> i2c_enable_out && !spi_enable_out)
    else $error("i2c not chosen");
  a_int_route: assert property (rt_bits == 3'h4 |=> shared_pin_oe_out && shared_pin_out == $past(int_flag_in))
    else $error("int flag not on pin");
  a_ready_route: assert property (s_ready_held |-> shared_pin_oe_out && shared_pin_out == sample_ready_out)
    else $error("ready flag not on pin");
  a_sdo_route: assert property (rt_bits == 3'h1 |=> shared_pin_oe_out && shared_pin_out == $past(spi_tx_bit_in))
    else $error("serial out not on pin");
  a_pin_released: assert property (rt_bits == 3'h0 |=> !shared_pin_oe_out)
    else $error("pin driven with no route");
  a_mix_refused: assert property ($countones(rt_bits) > 1 |-> route_error_out ##1 !shared_pin_oe_out)
    else $error("forbidden route mix not refused");
  a_flag_set: assert property (sample_done_in |=> sample_ready_out)
    else $error("ready flag not set");
  a_clock_edge: assert property ($rose(spc_level_out) |-> spc_rise_out)
    else $error("clock rise not flagged");
  a_clock_fall: assert property ($fell(spc_level_out) |-> spc_fall_out)
    else $error("clock fall not flagged");
endmodule

// ==== spf_host_model.sv ====
// host model: chip select, serial port clock and data line
`timescale 1ns/1ps
module spf_host_model
(
  input  wire logic dev_oe_in,
  input  wire logic dev_bit_in,
  output      logic cs_out,
  output      logic sck_out,
  output wire logic wire_out
);
  logic drv = 1'h0;
  logic val = 1'h0;
  // no pull-up: a released line shows the inverse of the last level
  assign wire_out = dev_oe_in ? dev_bit_in : (drv ? val : ~val);
  initial
  begin
    cs_out = 1'h1;
    sck_out = 1'h0;
  end
  task automatic cs_set(input logic v);
    cs_out = v;
  endtask
  // clock stands still outside frames; 200 ns period, msb first
  task automatic frame(input logic [7:0] d);
    #207;
    drv = 1'h1;
    for (int i = 7; i >= 0; i--)
    begin
      val = d[i];
      #100 sck_out = 1'h1;
      #100 sck_out = 1'h0;
    end
    drv = 1'h0;
  endtask
endmodule

// ==== spf_testbench.sv ====
// self-checking testbench for the pin function select block
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module testbench;
  import spf_pkg::*;
  logic clk_in, rst_b_in, chip_sel_in, serial_port_clock_in, sdat_in;
  logic sdat_out, sdat_oe_out, shared_pin_out, shared_pin_oe_out;
  logic int_route_sel_in, ready_route_sel_in, four_wire_out_sel_in, three_wire_sel_in;
  logic int_flag_in, sample_done_in, status_read_in, i2c_sda_low_in;
  logic spi_tx_bit_in, spi_tx_en_in, i2c_enable_out, spi_enable_out, route_error_out;
  logic spc_level_out, spc_rise_out, spc_fall_out, sdat_rx_out, sample_ready_out;
  logic [2:0] axis_done_in, axis_ready_out;
  spf_bus_t   bus_mode_out;
  logic [7:0] rx_byte;
  logic       exp_val;
  int         n_rise, n_fall, n_checks, n_mismatch;
  spf_pin_mux u_spf_pin_mux
  (
    .clk_in               (clk_in),
    .rst_b_in             (rst_b_in),
    .chip_sel_in          (chip_sel_in),
    .serial_port_clock_in (serial_port_clock_in),
    .sdat_in              (sdat_in),
    .sdat_out             (sdat_out),
    .sdat_oe_out          (sdat_oe_out),
    .shared_pin_out       (shared_pin_out),
    .shared_pin_oe_out    (shared_pin_oe_out),
    .int_route_sel_in     (int_route_sel_in),
    .ready_route_sel_in   (ready_route_sel_in),
    .four_wire_out_sel_in (four_wire_out_sel_in),
    .three_wire_sel_in    (three_wire_sel_in),
    .int_flag_in          (int_flag_in),
    .sample_done_in       (sample_done_in),
    .axis_done_in         (axis_done_in),
    .status_read_in       (status_read_in),
    .i2c_sda_low_in       (i2c_sda_low_in),
    .spi_tx_bit_in        (spi_tx_bit_in),
    .spi_tx_en_in         (spi_tx_en_in),
    .bus_mode_out         (bus_mode_out),
    .i2c_enable_out       (i2c_enable_out),
    .spi_enable_out       (spi_enable_out),
    .spc_level_out        (spc_level_out),
    .spc_rise_out         (spc_rise_out),
    .spc_fall_out         (spc_fall_out),
    .sdat_rx_out          (sdat_rx_out),
    .sample_ready_out     (sample_ready_out),
    .axis_ready_out       (axis_ready_out),
    .route_error_out      (route_error_out)
  );
  spf_host_model u_spf_host_model (.dev_oe_in(sdat_oe_out), .dev_bit_in(sdat_out),
    .cs_out(chip_sel_in), .sck_out(serial_port_clock_in), .wire_out(sdat_in));
  ////////////////////////////////////////
  initial
  begin
    clk_in = 1'h0;
    forever #12.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in)
  begin
    if (spc_rise_out)
    begin
      n_rise <= n_rise + 1;
      rx_byte <= {rx_byte[6:0], sdat_rx_out};
    end
    if (spc_fall_out)
      n_fall <= n_fall + 1;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic route(input logic [2:0] b);
    {int_route_sel_in, ready_route_sel_in, four_wire_out_sel_in} = b;
    cyc(2);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // the tests take under 4 us; twenty-five times that means a hang
  initial
  begin
    #100000;
    n_mismatch++;
    final_report();
  end
  ////////////////////////////////////////
  initial
  begin
    rst_b_in = 1'h0;
    {int_route_sel_in, ready_route_sel_in, four_wire_out_sel_in, three_wire_sel_in} = 4'h0;
    {int_flag_in, sample_done_in, status_read_in, i2c_sda_low_in} = 4'h0;
    {spi_tx_bit_in, spi_tx_en_in, axis_done_in} = 5'h00;
    n_rise = 0;
    n_fall = 0;
    n_checks = 0;
    n_mismatch = 0;
    rx_byte = 8'h00;
    cyc(10);
    `CHK("pin oe", 1'h0, shared_pin_oe_out)
    `CHK("i2c on", 1'h1, i2c_enable_out)
    rst_b_in = 1'h1;
    $display("reset test done");
    axis_done_in = 3'h5;
    sample_done_in = 1'h1;
    cyc(1);
    sample_done_in = 1'h0;
    `CHK("all ready", 1'h1, sample_ready_out)
    `CHK("axis ready", 3'h5, axis_ready_out)
    for (int p = 0; p < 2; p++)
    begin
      int_flag_in = p[0];
      spi_tx_bit_in = ~p[0];
      for (int i = 0; i < 8; i++)
      begin
        route(i[2:0]);
        exp_val = (i == 4) ? p[0] : ((i == 2) ? 1'h1 : ~p[0]);
        `CHK("pin oe", $countones(i) == 1, shared_pin_oe_out)
        `CHK("route error", $countones(i) > 1, route_error_out)
        if (i inside {1, 2, 4})
          `CHK("pin value", exp_val, shared_pin_out)
      end
    end
    route(3'h0);
    status_read_in = 1'h1;
    cyc(1);
    status_read_in = 1'h0;
    cyc(1);
    `CHK("ready cleared", 1'h0, sample_ready_out)
    `CHK("axis cleared", 3'h0, axis_ready_out)
    // completion and status read in one cycle: the completion must win
    {sample_done_in, status_read_in, axis_done_in} = 5'h1a;
    cyc(1);
    {sample_done_in, status_read_in} = 2'h0;
    `CHK("set wins", 1'h1, sample_ready_out)
    `CHK("axis set wins", 3'h2, axis_ready_out)
    $display("routing test done");
    i2c_sda_low_in = 1'h1;
    cyc(6);
    `CHK("sda drive", 2'h2, {sdat_oe_out, sdat_out})
    `CHK("sda seen", 1'h0, sdat_rx_out)
    i2c_sda_low_in = 1'h0;
    u_spf_host_model.cs_set(1'h0);
    {three_wire_sel_in, spi_tx_en_in, spi_tx_bit_in} = 3'h7;
    cyc(8);
    `CHK("spi on", 1'h1, spi_enable_out)
    `CHK("bus mode", SPF_BUS_SPI, bus_mode_out)
    `CHK("sdo drive", 2'h3, {sdat_oe_out, sdat_out})
    {three_wire_sel_in, spi_tx_en_in} = 2'h0;
    u_spf_host_model.frame(8'ha6);
    cyc(8);
    `CHK("clock edges", 32'h8, n_rise)
    `CHK("clock falls", 32'h8, n_fall)
    `CHK("data bits", 8'ha6, rx_byte)
    `CHK("sdi input", 1'h0, sdat_oe_out)
    u_spf_host_model.cs_set(1'h1);
    cyc(8);
    `CHK("i2c back", 1'h1, i2c_enable_out)
    $display("data pin test done");
    final_report();
  end
endmodule

bind spf_pin_mux spf_pin_mux_sva u_spf_pin_mux_sva
(
  .clk_in               (clk_in),
  .rst_b_in             (rst_b_in),
  .chip_sel_in          (chip_sel_in),
  .int_route_sel_in     (int_route_sel_in),
  .ready_route_sel_in   (ready_route_sel_in),
  .four_wire_out_sel_in (four_wire_out_sel_in),
  .int_flag_in          (int_flag_in),
  .spi_tx_bit_in        (spi_tx_bit_in),
  .sample_done_in       (sample_done_in),
  .shared_pin_out       (shared_pin_out),
  .shared_pin_oe_out    (shared_pin_oe_out),
  .i2c_enable_out       (i2c_enable_out),
  .spi_enable_out       (spi_enable_out),
  .spc_level_out        (spc_level_out),
  .spc_rise_out         (spc_rise_out),
  .spc_fall_out         (spc_fall_out),
  .sample_ready_out     (sample_ready_out),
  .route_error_out      (route_error_out)
);
